// ===== rtl/pods_regs.vh
`ifndef PODS_REGS_VH
`define PODS_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define PODS_ADDR_DT_PAIR_EN 8'hF9
`define PODS_ADDR_DT_COUNT_LO 8'hFA
`define PODS_ADDR_MASK_EN 8'hFB
`define PODS_ADDR_MASK_LEVEL 8'hFC
`define PODS_ADDR_CONTROL 8'hE0
`define PODS_ADDR_BRAKE 8'hE1
`define PODS_ADDR_INVERT 8'hE2
`define PODS_ADDR_UNLOCK 8'hE3
`define PODS_ADDR_STATUS 8'hE4

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PODS_DT_MSB_BIT 4
`define PODS_CTL_RUN_BIT 0
`define PODS_CTL_FAULT_EN_BIT 1
`define PODS_CTL_MODE_LO 2
`define PODS_CTL_MODE_HI 3
`define PODS_BRK_FLAG_BIT 7
`define PODS_BRK_EDGE_BIT 6
`define PODS_MODE_INDEP 2'h0
`define PODS_MODE_COMPL 2'h1
`define PODS_MODE_SYNC 2'h2

// ----------------------------------------------------------------------------
// Reset values and unlock keys
// ----------------------------------------------------------------------------
`define PODS_RST_BYTE 8'h00
`define PODS_UNLOCK_KEY1 8'hAA
`define PODS_UNLOCK_KEY2 8'h55

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PODS_CLK_MHZ 40
`define PODS_DEBOUNCE_CLKS 8
`define PODS_PERIOD_W 16

`endif

// ===== rtl/pods_deadtime.v
`timescale 1ns/100ps
`include "pods_regs.vh"

module pods_deadtime
(
  // Clock and reset
  input wire clk_in,
  input wire srst_in,
  // Control
  input wire enable_in,
  input wire [8:0] count_in,
  // Signal
  input wire sig_in,
  output wire sig_out
);

  reg [8:0] cnt_r;
  reg sig_r;

  // ----------------------------------------------------------------------------
  // Rising edges wait count plus one clocks; falling edges pass at once.
  // ----------------------------------------------------------------------------
  always @(posedge clk_in)
  begin
    if (srst_in)
    begin
      cnt_r <= 9'h000;
      sig_r <= 1'b0;
    end
    else if (!enable_in || !sig_in)
    begin
      cnt_r <= count_in;
      sig_r <= sig_in;
    end
    else if (!sig_r)
    begin
      if (cnt_r == 9'h000)
        sig_r <= 1'b1;
      else
        cnt_r <= cnt_r - 9'h001;
    end
  end

  assign sig_out = enable_in ? (sig_in & sig_r) : sig_in;

endmodule

// ===== rtl/pods_top.v
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
`include "pods_regs.vh"

// Overview of operation
// - Dead-time count is nine bits; delay equals count plus one clocks.
// - Dead-time acts only in complementary mode with the pair bit set.
// - One enable bit per pair delays that pair's rising edges.
// - Dead-time registers accept writes only right after the unlock sequence.
// - Synchronous mode copies each even channel onto its odd partner.
// - A set mask bit replaces the channel signal by its mask level.
// - Masked channel drives zero or one as its mask level bit says.
// - Mask enable resets to zero so channels follow their generators.
// - Masked levels still pass through per-channel output inversion.
// - Fault pin triggers a brake only while fault input is enabled.
// - On brake each output takes its own brake data bit, passed through output inversion.
// - On brake hardware clears the run bit.
// - On brake the sixteen-bit period counter resets to zero.
// - On brake hardware sets the brake flag.
// - Clearing the flag alone does not release the brake.
// - Setting run again releases the brake and resumes waveforms.
// - Software selects which fault pin edge triggers a brake.
// - Fault pin is debounced for eight clocks; shorter pulses ignored.
// - An ADC compare event brakes at once, with no fault enable, debounce or edge select.
// - Edge select zero means falling edge, one means rising edge.
// - Complementary mode makes odd channels the inverse of even ones.

module pods_top
(
  // Clock and reset
  input wire clk_in,
  input wire srst_in,
  // Register port
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  // Generator and fault sources
  input wire [5:0] gen_signal_in,
  input wire fault_pin_in,
  input wire adc_compare_in,
  // Outputs
  output reg [5:0] pwm_out,
  output reg waveform_run_out,
  output reg period_clear_out,
  output reg brake_flag_out
);

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  reg [7:0] deadtime_pair_enable_r;
  reg [7:0] deadtime_count_low_r;
  reg [5:0] output_mask_enable_r;
  reg [5:0] output_mask_level_r;
  reg [5:0] output_invert_r;
  reg [5:0] brake_data_r;
  reg fault_edge_select_r;
  reg fault_input_enable_r;
  reg [1:0] pair_mode_select_r;
  reg waveform_run_r;
  reg brake_flag_r;
  reg brake_active_r;
  reg [1:0] unlock_state_r;
  reg [7:0] fault_shift_r;
  reg fault_stable_r;
  reg fault_seen_r;
  reg [7:0] fault_fill_r;

  localparam UNL_IDLE = 2'h0;
  localparam UNL_KEY1 = 2'h1;
  localparam UNL_OPEN = 2'h2;

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  function wr_hit;
    input [7:0] addr;
    begin
      wr_hit = reg_wr_in && (reg_addr_in == addr);
    end
  endfunction

  function [7:0] pad6;
    input [5:0] val;
    begin
      pad6 = {2'h0, val};
    end
  endfunction

  // ----------------------------------------------------------------------------
  // Fault pin debounce and edge detection
  // ----------------------------------------------------------------------------
  // The pin is taken as synchronous; a level must hold eight clocks to count.
  wire fault_all_hi = &fault_shift_r;
  wire fault_all_lo = ~|fault_shift_r;
  // Eight ones here mean the shift register holds only real pin samples.
  wire fault_filled = &fault_fill_r;
  reg fault_stable_nxt;
  always @*
  begin
    fault_stable_nxt = fault_stable_r;
    if (fault_all_hi)
      fault_stable_nxt = 1'b1;
    else if (fault_all_lo)
      fault_stable_nxt = 1'b0;
  end

  wire fault_rise = fault_stable_nxt && !fault_stable_r;
  wire fault_fall = !fault_stable_nxt && fault_stable_r;
  wire fault_edge = fault_edge_select_r ? fault_rise : fault_fall;
  wire pin_event = fault_input_enable_r && fault_seen_r && fault_edge;
  wire brake_event = pin_event || adc_compare_in;

  always @(posedge clk_in)
  begin
    if (srst_in)
    begin
      fault_shift_r <= 8'h00;
      fault_stable_r <= 1'b0;
      fault_seen_r <= 1'b0;
      fault_fill_r <= 8'h00;
    end
    else
    begin
      fault_shift_r <= {fault_shift_r[6:0], fault_pin_in};
      fault_stable_r <= fault_stable_nxt;
      fault_fill_r <= {fault_fill_r[6:0], 1'b1};
      // The reset contents of the shift register are not pin samples, so the first
      // settled level only becomes a baseline once eight real samples are in.
      if (fault_filled && (fault_all_hi || fault_all_lo))
        fault_seen_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // Timed-access unlock
  // ----------------------------------------------------------------------------
  wire dt_write = wr_hit(`PODS_ADDR_DT_PAIR_EN) || wr_hit(`PODS_ADDR_DT_COUNT_LO);
  wire unlocked = (unlock_state_r == UNL_OPEN);

  always @(posedge clk_in)
  begin
    if (srst_in)
      unlock_state_r <= UNL_IDLE;
    else if (reg_wr_in)
    begin
      case (unlock_state_r)
        UNL_IDLE:
          if (reg_addr_in == `PODS_ADDR_UNLOCK && reg_wdata_in == `PODS_UNLOCK_KEY1)
            unlock_state_r <= UNL_KEY1;
        UNL_KEY1:
          if (reg_addr_in == `PODS_ADDR_UNLOCK && reg_wdata_in == `PODS_UNLOCK_KEY2)
            unlock_state_r <= UNL_OPEN;
          else
            unlock_state_r <= UNL_IDLE;
        // Any write, taken or not, closes the window: one write per unlock.
        default:
          unlock_state_r <= UNL_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------------
  always @(posedge clk_in)
  begin
    if (srst_in)
    begin
      deadtime_pair_enable_r <= `PODS_RST_BYTE;
      deadtime_count_low_r <= `PODS_RST_BYTE;
      output_mask_enable_r <= 6'h00;
      output_mask_level_r <= 6'h00;
      output_invert_r <= 6'h00;
      brake_data_r <= 6'h00;
      fault_edge_select_r <= 1'b0;
      fault_input_enable_r <= 1'b0;
      pair_mode_select_r <= `PODS_MODE_INDEP;
    end
    else
    begin
      if (dt_write && unlocked && reg_addr_in == `PODS_ADDR_DT_PAIR_EN)
        deadtime_pair_enable_r <= reg_wdata_in & 8'h17;
      if (dt_write && unlocked && reg_addr_in == `PODS_ADDR_DT_COUNT_LO)
        deadtime_count_low_r <= reg_wdata_in;
      if (wr_hit(`PODS_ADDR_MASK_EN))
        output_mask_enable_r <= reg_wdata_in[5:0];
      if (wr_hit(`PODS_ADDR_MASK_LEVEL))
        output_mask_level_r <= reg_wdata_in[5:0];
      if (wr_hit(`PODS_ADDR_INVERT))
        output_invert_r <= reg_wdata_in[5:0];
      if (wr_hit(`PODS_ADDR_BRAKE))
      begin
        brake_data_r <= reg_wdata_in[5:0];
        fault_edge_select_r <= reg_wdata_in[`PODS_BRK_EDGE_BIT];
      end
      if (wr_hit(`PODS_ADDR_CONTROL))
      begin
        fault_input_enable_r <= reg_wdata_in[`PODS_CTL_FAULT_EN_BIT];
        pair_mode_select_r <= reg_wdata_in[`PODS_CTL_MODE_HI:`PODS_CTL_MODE_LO];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Run, brake state and flag
  // ----------------------------------------------------------------------------
  wire run_write = wr_hit(`PODS_ADDR_CONTROL);
  wire run_set = run_write && reg_wdata_in[`PODS_CTL_RUN_BIT];
  wire flag_clear = wr_hit(`PODS_ADDR_BRAKE) && !reg_wdata_in[`PODS_BRK_FLAG_BIT];

  always @(posedge clk_in)
  begin
    if (srst_in)
    begin
      waveform_run_r <= 1'b0;
      brake_active_r <= 1'b0;
      brake_flag_r <= 1'b0;
    end
    else
    begin
      // A brake in the same cycle as a run write wins: safety before resume.
      if (brake_event)
      begin
        waveform_run_r <= 1'b0;
        brake_active_r <= 1'b1;
      end
      else if (run_write)
      begin
        waveform_run_r <= reg_wdata_in[`PODS_CTL_RUN_BIT];
        if (run_set)
          brake_active_r <= 1'b0;
      end
      // Flag set wins over a clear; the clear leaves the brake held.
      if (brake_event)
        brake_flag_r <= 1'b1;
      else if (flag_clear)
        brake_flag_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Pair mode and dead-time
  // ----------------------------------------------------------------------------
  wire [8:0] dt_count = {deadtime_pair_enable_r[`PODS_DT_MSB_BIT], deadtime_count_low_r};
  wire compl_mode = (pair_mode_select_r == `PODS_MODE_COMPL);
  wire sync_mode = (pair_mode_select_r == `PODS_MODE_SYNC);
  reg [5:0] paired;
  integer i;
  always @*
  begin
    paired = gen_signal_in;
    for (i = 0; i < 3; i = i + 1)
    begin
      if (compl_mode)
        paired[2 * i + 1] = ~gen_signal_in[2 * i];
      else if (sync_mode)
        paired[2 * i + 1] = gen_signal_in[2 * i];
    end
  end

  // Delaying each rising edge of both pair members keeps the two switches apart.
  wire [5:0] delayed;
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1)
    begin : dt_ch
      pods_deadtime u_dt
      (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .enable_in(compl_mode && deadtime_pair_enable_r[g / 2]),
        .count_in(dt_count),
        .sig_in(paired[g]),
        .sig_out(delayed[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // Mask, brake override and inversion
  // ----------------------------------------------------------------------------
  reg [5:0] masked;
  reg [5:0] braked;
  always @*
  begin
    masked = (delayed & ~output_mask_enable_r) |
      (output_mask_level_r & output_mask_enable_r);
    braked = (brake_active_r || brake_event) ? brake_data_r : masked;
  end

  always @(posedge clk_in)
  begin
    if (srst_in)
    begin
      pwm_out <= 6'h00;
      waveform_run_out <= 1'b0;
      period_clear_out <= 1'b0;
      brake_flag_out <= 1'b0;
    end
    else
    begin
      pwm_out <= braked ^ output_invert_r;
      waveform_run_out <= brake_event ? 1'b0 : waveform_run_r;
      period_clear_out <= brake_event;
      brake_flag_out <= brake_flag_r || brake_event;
    end
  end

  // ----------------------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------------------
  always @(posedge clk_in)
  begin
    if (srst_in)
      reg_rdata_out <= 8'h00;
    else if (reg_rd_in)
    begin
      case (reg_addr_in)
        `PODS_ADDR_DT_PAIR_EN: reg_rdata_out <= deadtime_pair_enable_r;
        `PODS_ADDR_DT_COUNT_LO: reg_rdata_out <= deadtime_count_low_r;
        `PODS_ADDR_MASK_EN: reg_rdata_out <= pad6(output_mask_enable_r);
        `PODS_ADDR_MASK_LEVEL: reg_rdata_out <= pad6(output_mask_level_r);
        `PODS_ADDR_INVERT: reg_rdata_out <= pad6(output_invert_r);
        `PODS_ADDR_BRAKE: reg_rdata_out <= {brake_flag_r, fault_edge_select_r, brake_data_r};
        `PODS_ADDR_CONTROL: reg_rdata_out <= {4'h0, pair_mode_select_r,
          fault_input_enable_r, waveform_run_r};
        `PODS_ADDR_STATUS: reg_rdata_out <= {4'h0, unlocked, fault_stable_r,
          brake_active_r, brake_flag_r};
        default: reg_rdata_out <= 8'h00;
      endcase
    end
    else
      reg_rdata_out <= 8'h00;
  end

endmodule

// ===== verif/pods_top_properties.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Port checker for the output stage
// ----------------------------------------------------------------------------
module pods_top_properties
(
  input wire clk_in,
  input wire srst_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_rdata_out,
  input wire [5:0] gen_signal_in,
  input wire fault_pin_in,
  input wire adc_compare_in,
  input wire [5:0] pwm_out,
  input wire waveform_run_out,
  input wire period_clear_out,
  input wire brake_flag_out
);
  reg [5:0] brk_r;
  reg [5:0] inv_r;
  reg [10:0] hist_r;
  wire run_wr = reg_wr_in && reg_addr_in == 8'hE0 && reg_wdata_in[0];
  wire flg_clr = reg_wr_in && reg_addr_in == 8'hE1 && !reg_wdata_in[7];
  // The filter may answer a few samples late, so any window of eight counts.
  function steady(input [10:0] h);
    integer j;
    begin
      steady = 1'b0;
      for (j = 0; j < 4; j = j + 1)
        steady = steady | (&h[j+:8]) | ~(|h[j+:8]);
    end
  endfunction
  always @(posedge clk_in)
  begin
    hist_r <= {hist_r[9:0], fault_pin_in};
    if (srst_in)
    begin
      brk_r <= 6'h00;
      inv_r <= 6'h00;
    end
    else if (reg_wr_in && reg_addr_in == 8'hE1)
      brk_r <= reg_wdata_in[5:0];
    else if (reg_wr_in && reg_addr_in == 8'hE2)
      inv_r <= reg_wdata_in[5:0];
  end
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (srst_in);
  a_adc_brake: assert property (adc_compare_in |=> brake_flag_out && period_clear_out)
    else $error("adc event gave no brake");
  a_brake_pins: assert property ($past(adc_compare_in) |-> pwm_out == (brk_r ^ inv_r))
    else $error("brake data not on pins");
  a_flag_hold: assert property (brake_flag_out && !$past(flg_clr) |=> brake_flag_out)
    else $error("flag dropped by itself");
  a_flag_clear: assert property (flg_clr |-> ##2
    (!brake_flag_out || period_clear_out || $past(period_clear_out)))
    else $error("flag not cleared");
  a_run_hold: assert property (!waveform_run_out && !$past(run_wr) |=> !waveform_run_out)
    else $error("run rose without write");
  a_run_set: assert property (run_wr |-> ##2
    (waveform_run_out || period_clear_out || $past(period_clear_out)))
    else $error("run write ignored");
  a_clear_pulse: assert property (period_clear_out |-> brake_flag_out && !waveform_run_out
    ##1 (!period_clear_out || $past(adc_compare_in)))
    else $error("counter clear malformed");
  a_fault_filter: assert property (period_clear_out && !$past(adc_compare_in) |->
    steady(hist_r))
    else $error("brake from short pulse");
  cover property (adc_compare_in ##1 brake_flag_out);
  cover property (period_clear_out && !$past(adc_compare_in));
  cover property (flg_clr ##2 !brake_flag_out);
endmodule

bind pods_top pods_top_properties pods_top_properties_inst
(
  .clk_in(clk_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .gen_signal_in(gen_signal_in), .fault_pin_in(fault_pin_in),
  .adc_compare_in(adc_compare_in), .pwm_out(pwm_out), .waveform_run_out(waveform_run_out),
  .period_clear_out(period_clear_out), .brake_flag_out(brake_flag_out)
);

// ===== verif/pods_fault_src.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// External fault source
// ----------------------------------------------------------------------------
module pods_fault_src
(
  input wire clk_in,
  input wire idle_in,
  input wire go_in,
  input wire [4:0] len_in,
  output reg fault_pin_out
);
  reg [4:0] cnt_r = 5'h00;
  always @(posedge clk_in)
  begin
    if (go_in)
      cnt_r <= len_in;
    else if (cnt_r != 5'h00)
      cnt_r <= cnt_r - 5'h01;
  end
  // A real fault lasts longer than the filter; the bench asks for short ones on purpose.
  always @*
    fault_pin_out = (cnt_r != 5'h00) ? ~idle_in : idle_in;
endmodule

// ===== verif/pods_top_tb.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Bench for the output stage
// ----------------------------------------------------------------------------
module pods_top_tb;
  reg clk_in = 1'b0;
  reg srst_in = 1'b1;
  reg [7:0] addr = 8'h00;
  reg [7:0] wdata = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [5:0] gen = 6'h00;
  reg adc = 1'b0;
  reg f_idle = 1'b1;
  reg f_go = 1'b0;
  reg [4:0] f_len = 5'h00;
  wire [7:0] rdata;
  wire [5:0] pins;
  wire run, pclr, flag, fpin;
  integer fail_count = 0;
  integer n_tests = 0;
  integer seed = 32'hDAFBD9A3;
  integer i, k;
  integer m_ctl = 0, m_inv = 0, m_men = 0, m_mlev = 0;

  always #12.5 clk_in = ~clk_in;

  pods_top pods_top_inst
  (
    .clk_in(clk_in), .srst_in(srst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .gen_signal_in(gen),
    .fault_pin_in(fpin), .adc_compare_in(adc), .pwm_out(pins), .waveform_run_out(run),
    .period_clear_out(pclr), .brake_flag_out(flag)
  );
  pods_fault_src pods_fault_src_inst
  (
    .clk_in(clk_in), .idle_in(f_idle), .go_in(f_go), .len_in(f_len), .fault_pin_out(fpin)
  );

  function [5:0] exp_pins(input [5:0] g);
    integer p;
    reg [5:0] s;
    begin
      s = g;
      for (p = 0; p < 3; p = p + 1)
        if (m_ctl[3:2] == 2)
          s[2*p+1] = g[2*p];
      s = (s & ~m_men[5:0]) | (m_mlev[5:0] & m_men[5:0]);
      exp_pins = s ^ m_inv[5:0];
    end
  endfunction

  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
        fail_count = fail_count + 1;
        $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
    end
  endtask

  task chk_pins(input [5:0] exp);
    chk({2'h0, pins}, {2'h0, exp});
  endtask

  task chk_stat(input [2:0] exp);
    chk({5'h00, flag, run, pclr}, {5'h00, exp});
  endtask

  task tick(input integer n);
    begin
      repeat (n) @(posedge clk_in);
      #1;
    end
  endtask

  task wr_reg(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_in);
      wr <= 1'b0;
      case (a)
        8'hE0: m_ctl = d;
        8'hE2: m_inv = d;
        8'hFB: m_men = d;
        8'hFC: m_mlev = d;
        default: ;
      endcase
    end
  endtask

  task rd_chk(input [7:0] a, input [7:0] exp);
    begin
      @(posedge clk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_in);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
    end
  endtask

  task unlock;
    begin
      wr_reg(8'hE3, 8'hAA);
      wr_reg(8'hE3, 8'h55);
    end
  endtask

  task pulse(input [4:0] n);
    begin
      @(posedge clk_in);
      f_len <= n;
      f_go <= 1'b1;
      @(posedge clk_in);
      f_go <= 1'b0;
    end
  endtask

  task stop_test;
    begin
      $display("Checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // The whole sequence needs about 440 cycles; the 20000-cycle limit, over forty times that, means a hang.
  initial
  begin
    #500000;
    fail_count = fail_count + 1;
    stop_test;
  end

  initial
  begin
    repeat (12) @(posedge clk_in);
    srst_in <= 1'b0;
    rd_chk(8'hFB, 8'h00);
    rd_chk(8'hFC, 8'h00);
    rd_chk(8'h3C, 8'h00);
    wr_reg(8'hFA, 8'h05);
    rd_chk(8'hFA, 8'h00);
    unlock;
    wr_reg(8'hFA, 8'h03);
    unlock;
    wr_reg(8'hF9, 8'hFF);
    rd_chk(8'hF9, 8'h17);
    unlock;
    wr_reg(8'hF9, 8'h01);
    rd_chk(8'hFA, 8'h03);
    rd_chk(8'hF9, 8'h01);
    wr_reg(8'hE0, 8'h05);
    tick(8);
    for (i = 0; i < 2; i = i + 1)
    begin
      @(posedge clk_in);
      gen <= i ? 6'h04 : 6'h05;
      for (k = 1; k < 6; k = k + 1)
      begin
        tick(1);
        chk_pins(6'h24 | ((k > 4) << i));
      end
    end
    for (k = 0; k < 3; k = k + 1)
    begin
      wr_reg(8'hE0, (k == 2) ? 8'h0D : (k == 1) ? 8'h09 : 8'h01);
      wr_reg(8'hE2, 8'($random(seed)));
      wr_reg(8'hFB, 8'($random(seed)));
      wr_reg(8'hFC, 8'($random(seed)));
      for (i = 0; i < 30; i = i + 1)
      begin
        @(posedge clk_in);
        gen <= 6'($random(seed));
        tick(1);
        chk_pins(exp_pins(gen));
      end
    end
    wr_reg(8'hE1, 8'h2A);
    @(posedge clk_in);
    adc <= 1'b1;
    @(posedge clk_in);
    adc <= 1'b0;
    #1;
    chk_pins(6'h2A ^ m_inv[5:0]);
    chk_stat(3'h5);
    tick(1);
    chk_stat(3'h4);
    wr_reg(8'hE1, 8'h2A);
    tick(1);
    chk_stat(3'h0);
    chk_pins(6'h2A ^ m_inv[5:0]);
    wr_reg(8'hE0, 8'h01);
    tick(1);
    chk_pins(exp_pins(gen));
    wr_reg(8'hFB, 8'h00);
    for (i = 0; i < 2; i = i + 1)
    begin
      wr_reg(8'hE0, 8'h01);
      wr_reg(8'hE1, i ? 8'h51 : 8'h11);
      f_idle <= !i;
      tick(12);
      pulse(12);
      tick(20);
      chk_stat(3'h2);
      wr_reg(8'hE0, 8'h03);
      pulse(5);
      tick(20);
      chk_stat(3'h2);
      pulse(12);
      tick(14);
      chk_stat(3'h4);
      chk_pins(6'h11 ^ m_inv[5:0]);
    end
    stop_test;
  end
endmodule
